// [rtl/sfcrs_pkg.sv]
// constants, types and helpers shared by the compare/rewrite/status block
package sfcrs_pkg;

  // ****************************************************************
  // command opcodes and frame lengths
  // ****************************************************************
  localparam logic [7:0] OP_CMP_B1 = 8'h60;
  localparam logic [7:0] OP_CMP_B2 = 8'h61;
  localparam logic [7:0] OP_RW_B1 = 8'h58;
  localparam logic [7:0] OP_RW_B2 = 8'h59;
  localparam logic [7:0] OP_STATUS = 8'hd7;
  localparam logic [5:0] OP_BITS = 6'h08;
  localparam logic [5:0] CMD_BITS = 6'h20;

  // ****************************************************************
  // address layout and page geometry
  // ****************************************************************
  localparam int PAGE_W = 12;
  localparam int BYTE_W = 10;
  localparam int STD_PAGE_LSB = 10;
  localparam int BIN_PAGE_LSB = 9;
  localparam logic [9:0] PAGE_LAST_STD = 10'h20f;
  localparam logic [9:0] PAGE_LAST_BIN = 10'h1ff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ****************************************************************
  // status word: first byte in [15:8], second byte in [7:0]
  // ****************************************************************
  localparam int SB1_RDY = 15;
  localparam int SB1_COMP = 14;
  localparam int SB1_DEN_LSB = 10;
  localparam int SB1_PROT = 9;
  localparam int SB1_PAGE = 8;
  localparam int SB2_RDY = 7;
  localparam int SB2_FAIL = 5;
  localparam int SB2_LOCK = 3;
  localparam int SB2_PS2 = 2;
  localparam int SB2_PS1 = 1;
  localparam int SB2_ES = 0;

  // sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CMP = 6'h02,
    ST_XFER = 6'h04,
    ST_ERASE = 6'h08,
    ST_PROG = 6'h10,
    ST_VERIFY = 6'h20
  } sfcrs_state_t;

  // true for the four-byte commands that start an array operation
  function automatic logic sfcrs_is_array_op(input logic [7:0] op);
    sfcrs_is_array_op = (op == OP_CMP_B1) || (op == OP_CMP_B2) ||
                        (op == OP_RW_B1) || (op == OP_RW_B2);
  endfunction

endpackage

// [rtl/sfcrs_link_if.sv]
// carrier between the serial-clock logic and the core sequencer
`timescale 1ns/100ps
interface sfcrs_link_if;
  logic [31:0] cmd_word;
  logic cmd_tog;
  logic [15:0] status_word;
  modport link (output cmd_word, output cmd_tog, input status_word);
  modport core (input cmd_word, input cmd_tog, output status_word);
endinterface

// [rtl/sfcrs_sync.sv]
// two-flop level synchroniser, any width
`timescale 1ns/100ps
module sfcrs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= INIT;
      q_reg <= INIT;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule // sfcrs_sync

// [rtl/sfcrs_link.sv]
// serial-clock side: command shifter and cyclic status shifter
`timescale 1ns/100ps
module sfcrs_link
  import sfcrs_pkg::*;
(
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic rst_n,
  output logic so,
  output logic so_oe,
  sfcrs_link_if.link lnk
);
  logic [5:0] cnt_reg, cnt_next;
  logic [30:0] sh_reg, sh_next;
  logic stat_reg, stat_next;
  logic [31:0] word;
  logic [31:0] cmd_reg, cmd_next;
  logic tog_reg, tog_next;
  logic [3:0] idx_reg, idx_next;
  logic [7:0] osh_reg, osh_next;
  logic so_reg, so_next;
  logic oe_reg, oe_next;
  logic [7:0] cur;

  // ****************************************************************
  // input side, rising edge; select high clears the frame
  // ****************************************************************
  assign word = {sh_reg, si};
  always_comb begin
    sh_next = word[30:0];
    cnt_next = (cnt_reg == CMD_BITS) ? cnt_reg : cnt_reg + 6'h01;
    stat_next = stat_reg |
                ((cnt_reg == OP_BITS - 6'h01) && (word[7:0] == OP_STATUS));
    cmd_next = cmd_reg;
    tog_next = tog_reg;
    // only a full 32-bit frame is handed over; short frames vanish
    if (cnt_reg == CMD_BITS - 6'h01 && sfcrs_is_array_op(word[31:24])) begin
      cmd_next = word;
      tog_next = ~tog_reg;
    end
  end

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      cnt_reg <= '0;
      sh_reg <= '0;
      stat_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      stat_reg <= stat_next;
    end
  end

  // command word survives the frame end so the core can read it
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg <= '0;
      tog_reg <= 1'b0;
    end else begin
      cmd_reg <= cmd_next;
      tog_reg <= tog_next;
    end
  end

  // ****************************************************************
  // output side, falling edge, msb first
  // ****************************************************************
  always_comb begin
    cur = idx_reg[3] ? lnk.status_word[7:0] : lnk.status_word[15:8];
    if (idx_reg[2:0] != 3'h0) begin
      cur = osh_reg;
    end
    so_next = cur[7];
    osh_next = {cur[6:0], 1'b0};
    idx_next = stat_reg ? idx_reg + 4'h1 : idx_reg;
    oe_next = stat_reg;
  end

  // select high floats the pin at once, mid-byte included
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      idx_reg <= '0;
      osh_reg <= '0;
      so_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      idx_reg <= idx_next;
      osh_reg <= osh_next;
      so_reg <= so_next;
      oe_reg <= oe_next;
    end
  end

  assign so = so_reg;
  assign so_oe = oe_reg;
  assign lnk.cmd_word = cmd_reg;
  assign lnk.cmd_tog = tog_reg;
endmodule // sfcrs_link

// [rtl/sfcrs_top.sv]
// page compare, page refresh and status read sequencer, top level
`timescale 1ns/100ps

// Function
// - select rising after compare starts it; busy throughout.
// - compare outcome lands in first status byte bit 6, 1 means differ.
// - select rising after refresh: page to buffer, erase, program back, busy.
// - opcode D7h then status bits leave on every following clock.
// - status repeats byte one, byte two while select low.
// - status read is served even while an operation runs.
// - ready/busy in both bytes, resampled for each byte.
// - select high ends status read at any bit; output floats.
// - first byte bit 7 is ready, low while busy.
// - first byte bits 5:2 hold a fixed capacity code.
// - first byte bit 1 reports sector protection enabled.
// - first byte bit 0 reports 512-byte page configuration.
// - second byte: ready, 0, fail, 0, lockdown, suspend two, one, erase.
// - fail flag reflects last program, set on any byte mismatch.
module sfcrs_top
  import sfcrs_pkg::*;
#(
  // capacity code reported in status; value is arbitrary
  parameter logic [3:0] DENSITY_CODE = 4'h5
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic page_bin_cfg,
  input wire logic protect_on,
  input wire logic lockdown_allowed_flag,
  input wire logic buffer_one_suspend_flag,
  input wire logic buffer_two_suspend_flag,
  input wire logic erase_halt_flag,
  output logic busy,
  output logic [PAGE_W-1:0] mem_page,
  output logic [BYTE_W-1:0] mem_byte,
  input wire logic [7:0] mem_rd_data,
  output logic mem_wr_en,
  output logic [7:0] mem_wr_data,
  output logic buf_sel,
  output logic [BYTE_W-1:0] buf_addr,
  input wire logic [7:0] buf_rd_data,
  output logic buf_wr_en,
  output logic [7:0] buf_wr_data
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_reg;
  logic rst_n_reg;

  // assert at once, release two edges later so no flop sees a runt
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ****************************************************************
  // link side and crossings
  // ****************************************************************
  sfcrs_link_if lnk ();
  logic [15:0] status_core;
  logic [15:0] status_reg;
  logic cs_hi_s;
  logic tog_s;

  sfcrs_link u_link (
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .rst_n(rst_n_reg),
    .so(so),
    .so_oe(so_oe),
    .lnk(lnk.link)
  );

  // select level into the core domain; idle is high
  sfcrs_sync #(.W(1), .INIT(1'b1)) u_cs_sync (
    .clk(clk),
    .arst_n(rst_n_reg),
    .d(cs_n),
    .q(cs_hi_s)
  );

  // command toggle into the core domain
  sfcrs_sync #(.W(1), .INIT(1'b0)) u_tog_sync (
    .clk(clk),
    .arst_n(rst_n_reg),
    .d(lnk.cmd_tog),
    .q(tog_s)
  );

  // status bits are slow levels; each bit crosses on its own, and a
  // bit caught mid-change only shows the old or new value for a byte
  sfcrs_sync #(.W(16), .INIT(16'h0000)) u_stat_sync (
    .clk(sck),
    .arst_n(rst_n_reg),
    .d(status_reg),
    .q(lnk.status_word)
  );

  // ****************************************************************
  // command pickup
  // ****************************************************************
  logic seen_reg, seen_next;
  logic pending;
  logic take;
  logic [7:0] op;
  logic [PAGE_W-1:0] page_sel;

  // a frame counts once its toggle arrived and select is back high;
  // the word is stable then because the link only rewrites it after
  // another 32 bits
  assign pending = tog_s ^ seen_reg;
  assign take = pending && cs_hi_s;
  assign op = lnk.cmd_word[31:24];
  // page index sits lower by one bit in the binary page layout
  assign page_sel = page_bin_cfg ?
      lnk.cmd_word[BIN_PAGE_LSB +: PAGE_W] :
      lnk.cmd_word[STD_PAGE_LSB +: PAGE_W];

  always_comb begin
    seen_next = take ? tog_s : seen_reg;
  end

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      seen_reg <= 1'b0;
    end else begin
      seen_reg <= seen_next;
    end
  end

  // ****************************************************************
  // array sequencer
  // ****************************************************************
  // the walk is one page per command; the array and the buffers sit
  // outside and answer reads in the same cycle as the address.
  // limitation: a command that arrives while busy is lost, so the host
  // polls ready before it sends the next array command.
  // trade-off: the refresh spends two cycles per written byte so the
  // write strobe never shares a cycle with an address change.
  sfcrs_state_t state_reg, state_next;
  logic [PAGE_W-1:0] page_reg, page_next;
  logic [BYTE_W-1:0] idx_reg, idx_next;
  logic [BYTE_W-1:0] last_reg, last_next;
  logic phase_reg, phase_next;
  logic bsel_reg, bsel_next;
  logic diff_reg, diff_next;
  logic comp_reg, comp_next;
  logic fail_reg, fail_next;
  logic mwe_reg, mwe_next;
  logic [7:0] mwd_reg, mwd_next;
  logic bwe_reg, bwe_next;
  logic [7:0] bwd_reg, bwd_next;
  logic at_last;
  logic mismatch;

  assign at_last = (idx_reg == last_reg);
  assign mismatch = (mem_rd_data != buf_rd_data);

  // each write step takes two cycles: address, then write strobe
  always_comb begin
    state_next = state_reg;
    page_next = page_reg;
    idx_next = idx_reg;
    last_next = last_reg;
    phase_next = 1'b0;
    bsel_next = bsel_reg;
    diff_next = diff_reg;
    comp_next = comp_reg;
    fail_next = fail_reg;
    mwe_next = 1'b0;
    mwd_next = mwd_reg;
    bwe_next = 1'b0;
    bwd_next = bwd_reg;
    case (state_reg)
      ST_IDLE: begin
        // a command that lands while busy is dropped
        if (take) begin
          page_next = page_sel;
          idx_next = '0;
          last_next = page_bin_cfg ? PAGE_LAST_BIN : PAGE_LAST_STD;
          bsel_next = op[0];
          diff_next = 1'b0;
          if (op == OP_CMP_B1 || op == OP_CMP_B2) begin
            state_next = ST_CMP;
          end else if (op == OP_RW_B1 || op == OP_RW_B2) begin
            state_next = ST_XFER;
          end
        end
      end
      ST_CMP: begin
        // one byte per cycle over the whole page
        diff_next = diff_reg | mismatch;
        idx_next = idx_reg + 10'h001;
        if (at_last) begin
          comp_next = diff_reg | mismatch;
          state_next = ST_IDLE;
        end
      end
      ST_XFER: begin
        // page byte into the chosen buffer
        if (!phase_reg) begin
          bwd_next = mem_rd_data;
          bwe_next = 1'b1;
          phase_next = 1'b1;
        end else if (at_last) begin
          idx_next = '0;
          state_next = ST_ERASE;
        end else begin
          idx_next = idx_reg + 10'h001;
        end
      end
      ST_ERASE: begin
        if (!phase_reg) begin
          mwd_next = ERASED_BYTE;
          mwe_next = 1'b1;
          phase_next = 1'b1;
        end else if (at_last) begin
          idx_next = '0;
          state_next = ST_PROG;
        end else begin
          idx_next = idx_reg + 10'h001;
        end
      end
      ST_PROG: begin
        // buffer byte back into the same page
        if (!phase_reg) begin
          mwd_next = buf_rd_data;
          mwe_next = 1'b1;
          phase_next = 1'b1;
        end else if (at_last) begin
          idx_next = '0;
          diff_next = 1'b0;
          state_next = ST_VERIFY;
        end else begin
          idx_next = idx_reg + 10'h001;
        end
      end
      ST_VERIFY: begin
        // read back after program; any bad byte marks the failure
        diff_next = diff_reg | mismatch;
        idx_next = idx_reg + 10'h001;
        if (at_last) begin
          fail_next = diff_reg | mismatch;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= ST_IDLE;
      page_reg <= '0;
      idx_reg <= '0;
      last_reg <= PAGE_LAST_STD;
      phase_reg <= 1'b0;
      bsel_reg <= 1'b0;
      diff_reg <= 1'b0;
      comp_reg <= 1'b0;
      fail_reg <= 1'b0;
      mwe_reg <= 1'b0;
      mwd_reg <= '0;
      bwe_reg <= 1'b0;
      bwd_reg <= '0;
    end else begin
      state_reg <= state_next;
      page_reg <= page_next;
      idx_reg <= idx_next;
      last_reg <= last_next;
      phase_reg <= phase_next;
      bsel_reg <= bsel_next;
      diff_reg <= diff_next;
      comp_reg <= comp_next;
      fail_reg <= fail_next;
      mwe_reg <= mwe_next;
      mwd_reg <= mwd_next;
      bwe_reg <= bwe_next;
      bwd_reg <= bwd_next;
    end
  end

  // ****************************************************************
  // memory ports, all from flops
  // ****************************************************************
  assign mem_page = page_reg;
  assign mem_byte = idx_reg;
  assign mem_wr_en = mwe_reg;
  assign mem_wr_data = mwd_reg;
  assign buf_sel = bsel_reg;
  assign buf_addr = idx_reg;
  assign buf_wr_en = bwe_reg;
  assign buf_wr_data = bwd_reg;
  assign busy = (state_reg != ST_IDLE);

  // ****************************************************************
  // status word, rebuilt every cycle for the link
  // ****************************************************************
  always_comb begin
    status_core = '0;
    status_core[SB1_RDY] = ~busy;
    status_core[SB1_COMP] = comp_reg;
    status_core[SB1_DEN_LSB +: 4] = DENSITY_CODE;
    status_core[SB1_PROT] = protect_on;
    status_core[SB1_PAGE] = page_bin_cfg;
    status_core[SB2_RDY] = ~busy;
    status_core[SB2_FAIL] = fail_reg;
    status_core[SB2_LOCK] = lockdown_allowed_flag;
    status_core[SB2_PS2] = buffer_two_suspend_flag;
    status_core[SB2_PS1] = buffer_one_suspend_flag;
    status_core[SB2_ES] = erase_halt_flag;
  end

  // ****************************************************************
  // status word crossing
  // ****************************************************************
  // register the word before it crosses so the serial side never
  // samples a glitch from the decode above
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_core;
    end
  end

endmodule // sfcrs_top

// [test/sfcrs_checker.sv]
// concurrent checks on the top-level ports of the sequencer
`timescale 1ns/100ps
module sfcrs_checker
  import sfcrs_pkg::*;
#(
  parameter logic [3:0] DENSITY_CODE = 4'h5
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic busy,
  input wire logic mem_wr_en,
  input wire logic buf_wr_en,
  input wire logic [BYTE_W-1:0] mem_byte,
  input wire logic page_bin_cfg
);
  // ****************************************************************
  // helper counters
  // ****************************************************************
  logic [7:0] bit_cnt;
  logic [7:0] op_sr;
  logic [3:0] ph;
  logic [11:0] blen_reg;
  logic [11:0] blen_next;

  // frame bit count and opcode capture; select high clears both
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= 8'h00;
      op_sr <= 8'h00;
    end else begin
      bit_cnt <= bit_cnt + 8'h01;
      if (bit_cnt < 8'h08) op_sr <= {op_sr[6:0], si};
    end
  end
  assign ph = bit_cnt[3:0] - 4'h8; // bit slot within the status word

  // busy run length, saturating so long refreshes do not wrap
  always_comb begin
    blen_next = 12'h000;
    if (busy) blen_next = (&blen_reg) ? blen_reg : blen_reg + 12'h001;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) blen_reg <= 12'h000;
    else blen_reg <= blen_next;
  end

  oe_float_a: assert property (@(posedge clk) disable iff (!rstn)
    cs_n && $past(cs_n) |-> !so_oe) else $error("so driven while idle");
  oe_start_a: assert property (@(posedge sck) disable iff (cs_n)
    $rose(so_oe) |-> bit_cnt == 8'h08) else $error("status start slot");
  op_gate_a: assert property (@(posedge sck) disable iff (cs_n)
    so_oe |-> op_sr == OP_STATUS && bit_cnt >= 8'h08)
    else $error("so driven without status opcode");
  dens_bits_a: assert property (@(posedge sck) disable iff (cs_n)
    so_oe && ph >= 4'h2 && ph <= 4'h5 |-> so == DENSITY_CODE[4'h5 - ph])
    else $error("capacity code bit wrong");
  rsvd_zero_a: assert property (@(posedge sck) disable iff (cs_n)
    so_oe && (ph == 4'h9 || ph == 4'hb) |-> !so)
    else $error("reserved status bit set");
  busy_start_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(busy) |-> cs_n && $past(cs_n, 2)) else $error("busy w/o select");
  busy_len_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(busy) |-> blen_reg >= 12'h1ff) else $error("busy too short");
  wr_idle_a: assert property (@(posedge clk) disable iff (!rstn)
    mem_wr_en || buf_wr_en |-> busy) else $error("write while idle");
  byte_range_a: assert property (@(posedge clk) disable iff (!rstn)
    mem_wr_en |-> mem_byte <= (page_bin_cfg ? PAGE_LAST_BIN : PAGE_LAST_STD))
    else $error("byte beyond page");

  cov_status: cover property (@(posedge sck) $rose(so_oe));
  cov_busy: cover property (@(posedge clk) $rose(busy));
  cov_prog: cover property (@(posedge clk) mem_wr_en);
  cov_xfer: cover property (@(posedge clk) buf_wr_en);
endmodule // sfcrs_checker

bind sfcrs_top sfcrs_checker #(.DENSITY_CODE(DENSITY_CODE)) u_chk (
  .clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
  .so_oe(so_oe), .busy(busy), .mem_wr_en(mem_wr_en),
  .buf_wr_en(buf_wr_en), .mem_byte(mem_byte), .page_bin_cfg(page_bin_cfg));

// [test/sfcrs_host.sv]
// serial host model: select, link clock and data in, data out read back
`timescale 1ns/100ps
module sfcrs_host (
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so
);
  // clock stands low between frames
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  // one frame at 6 ns per bit: select low throughout all clocking
  task automatic xfer(input logic [31:0] tx, input int ntx, input int nrx,
                      output logic [31:0] rx);
    rx = '0;
    #1.3 cs_n = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      if (i < ntx) si = tx[31-i];
      else si = ~si; // released line shows no stale level
      #3 sck = 1'b1;
      rx = {rx[30:0], so};
      #3 sck = 1'b0;
    end
    #2 cs_n = 1'b1;
    #40; // select high long enough for the core to see it
  endtask
endmodule // sfcrs_host

// [test/sfcrs_top_bench.sv]
// self-checking bench for the compare, refresh and status sequencer
`timescale 1ns/100ps
module sfcrs_top_bench;
  import sfcrs_pkg::*;
  // ****************************************************************
  // signals, models and shared tasks
  // ****************************************************************
  localparam logic [3:0] DENS = 4'h9; // arbitrary capacity code
  logic clk, rstn, sck, cs_n, si, so, so_oe, busy, mem_wr_en, buf_sel;
  logic page_bin_cfg, protect_on, lock, ps1, ps2, es, buf_wr_en;
  logic stuck, exp_comp, exp_fail;
  logic [PAGE_W-1:0] mem_page;
  logic [BYTE_W-1:0] mem_byte, buf_addr;
  logic [7:0] mem_rd_data, mem_wr_data, buf_rd_data, buf_wr_data;
  logic [7:0] mem [0:1023];
  logic [7:0] bufm [0:1][0:1023];
  logic [7:0] snap [0:1023];
  logic [15:0] wcnt;
  int miscompares, n_checks;

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // page and buffer model; stuck clears bit 0 to force verify failures
  assign mem_rd_data = mem[mem_byte];
  assign buf_rd_data = bufm[buf_sel][buf_addr];
  always @(posedge clk) begin
    if (mem_wr_en === 1'b1) begin
      mem[mem_byte] <= stuck ? (mem_wr_data & 8'hfe) : mem_wr_data;
      wcnt <= wcnt + 16'h0001;
    end
    if (buf_wr_en === 1'b1) bufm[buf_sel][buf_addr] <= buf_wr_data;
  end

  sfcrs_host host (.cs_n(cs_n), .sck(sck), .si(si), .so(so));
  sfcrs_top #(.DENSITY_CODE(DENS)) DUT (
    .clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe), .page_bin_cfg(page_bin_cfg), .protect_on(protect_on),
    .lockdown_allowed_flag(lock), .buffer_one_suspend_flag(ps1),
    .buffer_two_suspend_flag(ps2), .erase_halt_flag(es), .busy(busy),
    .mem_page(mem_page), .mem_byte(mem_byte), .mem_rd_data(mem_rd_data),
    .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data), .buf_sel(buf_sel),
    .buf_addr(buf_addr), .buf_rd_data(buf_rd_data),
    .buf_wr_en(buf_wr_en), .buf_wr_data(buf_wr_data));

  task automatic stop_test();
    if (miscompares == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_st(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_st({15'h0000, got}, {15'h0000, exp});
  endtask

  // expected status word from the current inputs and tracked flags
  function automatic logic [15:0] exp_st(input logic rdy);
    exp_st = {rdy, exp_comp, DENS, protect_on, page_bin_cfg,
              rdy, 1'b0, exp_fail, 1'b0, lock, ps2, ps1, es};
  endfunction

  // page index lands at bits 21:10 or 20:9 depending on page size
  function automatic logic [23:0] pg_addr(input logic bin,
                                          input logic [11:0] pg);
    pg_addr = bin ? {3'h0, pg, 9'h000} : {2'h0, pg, 10'h000};
  endfunction

  // two status words; both fresh, the opcode clocks flush the crossing
  task automatic rd_st(output logic [31:0] rx);
    host.xfer({OP_STATUS, 24'h000000}, 8, 32, rx);
  endtask

  // bounded wait; limit covers the longest refresh walk
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk_bit(busy, lvl);
  endtask

  task automatic t_status();
    logic [31:0] rx;
    for (int k = 0; k < 2; k++) begin
      @(negedge clk);
      {protect_on, lock, ps2, ps1, es, page_bin_cfg} = k ? 6'h2a : 6'h15;
      host.xfer({OP_STATUS, 24'h000000}, 8, 5, rx);
      @(negedge clk);
      chk_bit(so_oe, 1'b0);
      rd_st(rx);
      chk_st(rx[15:0], exp_st(1'b1));
      chk_st(rx[31:16], rx[15:0]);
    end
  endtask

  task automatic t_cmp(input logic [7:0] op, input logic bin,
                       input logic [11:0] pg, input logic cmp);
    logic [31:0] rx;
    @(negedge clk);
    page_bin_cfg = bin;
    host.xfer({op, pg_addr(bin, pg)}, 32, 0, rx);
    wait_busy(1'b1);
    chk_st({4'h0, mem_page}, {4'h0, pg});
    chk_bit(buf_sel, op[0]);
    rd_st(rx);
    chk_bit(rx[15], 1'b0);
    chk_bit(rx[7], 1'b0);
    wait_busy(1'b0);
    exp_comp = cmp;
    rd_st(rx);
    chk_st(rx[15:0], exp_st(1'b1));
  endtask

  // compare frame cut after three bytes must leave everything alone
  task automatic t_short();
    logic [31:0] rx;
    host.xfer({OP_CMP_B1, 24'h000000}, 24, 0, rx);
    repeat (20) @(negedge clk);
    chk_bit(busy, 1'b0);
    rd_st(rx);
    chk_st(rx[15:0], exp_st(1'b1));
  endtask

  task automatic t_rw(input logic [7:0] op, input logic bin, input logic bad);
    logic [31:0] rx;
    logic e;
    e = 1'b0;
    @(negedge clk);
    for (int i = 0; i < 1024; i++) snap[i] = mem[i];
    page_bin_cfg = bin;
    stuck = bad;
    wcnt = 16'h0000;
    host.xfer({op, pg_addr(bin, 12'h042)}, 32, 0, rx);
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk_st(wcnt, bin ? 16'h0400 : 16'h0420);
    for (int i = 0; i < (bin ? 512 : 528); i++) begin
      if (bufm[op[0]][i] !== snap[i]) e = 1'b1;
      if (!bad && mem[i] !== snap[i]) e = 1'b1;
    end
    chk_bit(e, 1'b0);
    exp_fail = bad;
    rd_st(rx);
    chk_st(rx[15:0], exp_st(1'b1));
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    rstn = 1'b0;
    {page_bin_cfg, protect_on, lock, ps1, ps2, es, stuck} = 7'h00;
    exp_comp = 1'b0;
    exp_fail = 1'b0;
    miscompares = 0;
    n_checks = 0;
    wcnt = 16'h0000;
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
      bufm[0][i] = 8'(i) ^ 8'h5a;
      bufm[1][i] = (i == 527 || i == 600) ? 8'h00 : 8'(i) ^ 8'h5a;
    end
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    t_status();
    t_cmp(OP_CMP_B1, 1'b0, 12'h123, 1'b0);
    t_cmp(OP_CMP_B2, 1'b0, 12'h0a5, 1'b1);
    t_short();
    t_cmp(OP_CMP_B2, 1'b1, 12'hfff, 1'b0);
    t_rw(OP_RW_B1, 1'b1, 1'b1);
    t_rw(OP_RW_B2, 1'b0, 1'b0);
    stop_test();
  end

  // whole run needs well under 150 us
  initial begin
    #400000;
    miscompares++;
    stop_test();
  end
endmodule // sfcrs_top_bench
